/* dcc_pkg.sv */
package dcc_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ROW_W   = 14;
   localparam int COL_W   = 10;
   localparam int BANK_N  = 4;
   localparam int BA_W    = 2;
   localparam int DQ_W    = 8;
   localparam int AL_W    = 3;
   localparam int CNT_W   = 8;
   localparam int MR_N    = 4;
   localparam int FIFO_DEPTH = 16;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int AUTO_PRE_BIT = 10;
   localparam int AL_LSB       = 3;   // additive latency field of ext mode reg
   localparam int ODT_BIT_A    = 2;   // termination enable bits
   localparam int ODT_BIT_B    = 6;
   localparam logic [BA_W-1:0] MR_EXT1 = 2'h1;
   // ---------------------------------------------------------------
   // timing in clocks and reset values
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] ROW_PRECHARGE_TIME      = 8'h03;
   localparam logic [CNT_W-1:0] MODE_REGISTER_SET_DELAY = 8'h02;
   localparam logic [CNT_W-1:0] SR_EXIT_READ_DELAY      = 8'hc8; // 200 clocks
   localparam logic [CNT_W-1:0] BURST_LEN               = 8'h04;
   localparam logic [ROW_W-1:0] MR_RESET                = 14'h0000;
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PW_ACTIVE, PW_POWER_DOWN, PW_SELF_REFRESH} dcc_pwr_e;
endpackage

/* dcc_fifo.sv */
`timescale 1ns/10ps
module dcc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // drain side
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   wire              doPush = inValid && inReady;
   wire              doPop  = outValid && outReady;
   // honest full and empty from pointer wrap bits
   assign inReady  = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outValid = (wrPtr != rdPtr);
   assign outData  = mem[rdPtr[AW-1:0]];
   // pointers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (doPush) wrPtr <= wrPtr + 1'b1;
         if (doPop) rdPtr <= rdPtr + 1'b1;
      end
   end
   // storage needs no reset
   always_ff @(posedge core_clk) begin
      if (doPush) mem[wrPtr[AW-1:0]] <= inData;
   end
endmodule

/* dcc_cmd_ctrl.sv */
// Summary of operation
// - cke fall with nop: active/precharge power down
// - refresh with cke fall enters self refresh
// - no refresh happens in power down
// - termination valid in active and power down, off in self refresh
// - masked write bytes stay unchanged
// - deselect ignores commands, work continues
// - nop decodes, work continues
// - bank inputs choose mode register
// - activate opens row until precharged
// - read at column, a10 auto precharge
// - write at column, a10 auto precharge
// - additive latency delays column command
// - precharge closes row, idle after delay
// - precharge to idle bank restarts timing
// - refresh needs idle banks, internal address
// - self refresh turns delay loop off/on
// - commands decoded at rising edge
// - self refresh exit seen synchronously, through the registered cke
`timescale 1ns/10ps
module dcc_cmd_ctrl
   import dcc_pkg::*;
(
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // command pins, active low strobes
   input  wire logic                    cke,
   input  wire logic                    csN,
   input  wire logic                    rasN,
   input  wire logic                    casN,
   input  wire logic                    weN,
   input  wire logic [dcc_pkg::BA_W-1:0]  bankAddr,
   input  wire logic [dcc_pkg::ROW_W-1:0] addr,
   // write data with mask
   input  wire logic                    wrDataValid,
   input  wire logic [dcc_pkg::DQ_W-1:0]  wrData,
   input  wire logic                    dataMask,
   // stored write data towards the array
   output logic                         arrayWrValid,
   output logic [dcc_pkg::DQ_W-1:0]       arrayWrData,
   input  wire logic                    arrayWrReady,
   output logic                         wrDataReady,
   // state outputs
   output logic [dcc_pkg::BANK_N-1:0]     bankOpen,
   output logic                         powerDown,
   output logic                         activePowerDown,
   output logic                         selfRefresh,
   output logic                         dllEnable,
   output logic                         odtAllowed,
   output logic                         readPermitted,
   output logic                         colStart,
   output logic                         colIsWrite,
   output logic [dcc_pkg::COL_W-1:0]      colAddr,
   output logic                         refreshPulse
);
   import dcc_pkg::*;

   // ---------------------------------------------------------------
   // input registration
   // ---------------------------------------------------------------
   logic [2:0] ckeSync;
   logic       ckePrev;
   logic       ckeNow;
   // cke passes three flops; level counts once stage two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) ckeSync <= 3'h0;
      else ckeSync <= {ckeSync[1:0], cke};
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ckeNow  <= 1'b0;
         ckePrev <= 1'b0;
      end else begin
         if (ckeSync[1] == ckeSync[2]) ckeNow <= ckeSync[2];
         ckePrev <= ckeNow;
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   // decode on rising edge
   wire sel      = ~csN;
   wire isNop    = ~sel || (rasN && casN && weN);
   wire ckeStay  = ckePrev && ckeNow;
   wire ckeFall  = ckePrev && !ckeNow;
   wire ckeRise  = !ckePrev && ckeNow;
   wire cmdMrs   = ckeStay && sel && !rasN && !casN && !weN;
   wire cmdRef   = ckeStay && sel && !rasN && !casN && weN;
   wire cmdSrEn  = ckeFall && sel && !rasN && !casN && weN;
   wire cmdPre   = ckeStay && sel && !rasN && casN && !weN;
   wire cmdAct   = ckeStay && sel && !rasN && casN && weN;
   wire cmdWr    = ckeStay && sel && rasN && !casN && !weN;
   wire cmdRd    = ckeStay && sel && rasN && !casN && weN;
   wire preAll   = addr[AUTO_PRE_BIT];
   // per-bank precharge timers, driven in the bank section below
   logic [BANK_N-1:0] bankBusy;
   wire allIdle  = (bankOpen == '0) && (bankBusy == '0);

   // ---------------------------------------------------------------
   // mode registers
   // ---------------------------------------------------------------
   logic [ROW_W-1:0] modeReg [MR_N];
   logic [CNT_W-1:0] mrdCnt;
   wire  [AL_W-1:0]  addLat   = modeReg[MR_EXT1][AL_LSB +: AL_W];
   wire              odtOn    = modeReg[MR_EXT1][ODT_BIT_A] | modeReg[MR_EXT1][ODT_BIT_B];
   // load accepted only with idle banks
   wire              mrsTake  = cmdMrs && allIdle;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MR_N; i++) modeReg[i] <= MR_RESET;
      end else if (mrsTake) begin
         modeReg[bankAddr] <= addr;
      end
   end
   // load delay keeps power down off while the load settles
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) mrdCnt <= '0;
      else if (mrsTake) mrdCnt <= MODE_REGISTER_SET_DELAY;
      else if (mrdCnt != '0) mrdCnt <= mrdCnt - 1'b1;
   end

   // ---------------------------------------------------------------
   // per-bank row and precharge state
   // ---------------------------------------------------------------
   logic [BANK_N-1:0] autoPre;
   logic [CNT_W-1:0]  burstCnt;
   logic [BA_W-1:0]   burstBank;
   wire               burstEnd = (burstCnt == 8'h01);
   genvar b;
   generate
      for (b = 0; b < BANK_N; b++) begin : g_bank
         logic [CNT_W-1:0] rpCnt;
         wire hitBank  = (bankAddr == BA_W'(b));
         wire preHit   = cmdPre && (preAll || hitBank);
         wire autoHit  = burstEnd && autoPre[b] && (burstBank == BA_W'(b));
         wire actHit   = cmdAct && hitBank && !bankOpen[b] && !bankBusy[b];
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               bankOpen[b] <= 1'b0;
               rpCnt       <= '0;
            end else begin
               if (preHit || autoHit) begin
                  bankOpen[b] <= 1'b0;
                  rpCnt       <= ROW_PRECHARGE_TIME;
               end else begin
                  if (actHit) bankOpen[b] <= 1'b1;
                  if (rpCnt != '0) rpCnt <= rpCnt - 1'b1;
               end
            end
         end
         assign bankBusy[b] = (rpCnt != '0);
      end
   endgenerate

   // ---------------------------------------------------------------
   // column commands through the additive latency line
   // ---------------------------------------------------------------
   localparam int AL_MAX = 8;
   logic [AL_MAX-1:0] pipeVld;
   logic [AL_MAX-1:0] pipeWr;
   logic [AL_MAX-1:0] pipeAp;
   logic [COL_W-1:0]  pipeCol [AL_MAX];
   logic [BA_W-1:0]   pipeBank [AL_MAX];
   wire colIn = cmdRd || cmdWr;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pipeVld <= '0;
         pipeWr  <= '0;
         pipeAp  <= '0;
         for (int i = 0; i < AL_MAX; i++) begin
            pipeCol[i]  <= '0;
            pipeBank[i] <= '0;
         end
      end else begin
         pipeVld <= {pipeVld[AL_MAX-2:0], 1'b0};
         pipeWr  <= {pipeWr[AL_MAX-2:0], 1'b0};
         pipeAp  <= {pipeAp[AL_MAX-2:0], 1'b0};
         for (int i = 1; i < AL_MAX; i++) begin
            pipeCol[i]  <= pipeCol[i-1];
            pipeBank[i] <= pipeBank[i-1];
         end
         pipeVld[0]  <= colIn;
         pipeWr[0]   <= cmdWr;
         pipeAp[0]   <= addr[AUTO_PRE_BIT];
         pipeCol[0]  <= addr[COL_W-1:0];
         pipeBank[0] <= bankAddr;
      end
   end
   wire colFire = pipeVld[addLat];
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         colStart   <= 1'b0;
         colIsWrite <= 1'b0;
         colAddr    <= '0;
         burstCnt   <= '0;
         burstBank  <= '0;
         autoPre    <= '0;
      end else begin
         colStart <= colFire;
         if (colFire) begin
            colIsWrite                  <= pipeWr[addLat];
            colAddr                     <= pipeCol[addLat];
            burstCnt                    <= BURST_LEN;
            burstBank                   <= pipeBank[addLat];
            autoPre[pipeBank[addLat]]   <= pipeAp[addLat];
         end else if (burstCnt != '0) begin
            burstCnt <= burstCnt - 1'b1;
            if (burstEnd) autoPre[burstBank] <= 1'b0;
         end
      end
   end
   wire colBusy = (pipeVld != '0) || (burstCnt != '0);

   // ---------------------------------------------------------------
   // power state machine
   // ---------------------------------------------------------------
   dcc_pwr_e         pwrState;
   dcc_pwr_e         next_pwrState;
   logic [CNT_W-1:0] xsrdCnt;
   wire busyNow  = colBusy || (mrdCnt != '0) || (bankBusy != '0);
   wire pdEnter  = ckeFall && isNop && !busyNow;
   wire srEnter  = cmdSrEn && allIdle && !busyNow;
   always_comb begin
      next_pwrState = pwrState;
      unique case (pwrState)
         PW_ACTIVE: begin
            // power down flavour by bank state
            if (srEnter) next_pwrState = PW_SELF_REFRESH;
            else if (pdEnter) next_pwrState = PW_POWER_DOWN;
         end
         PW_POWER_DOWN: begin
            if (ckeRise && isNop) next_pwrState = PW_ACTIVE;
         end
         PW_SELF_REFRESH: begin
            // exit follows cke alone, no commands
            if (ckeRise) next_pwrState = PW_ACTIVE;
         end
      endcase
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) pwrState <= PW_ACTIVE;
      else pwrState <= next_pwrState;
   end
   // read window opens 200 clocks after exit
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) xsrdCnt <= '0;
      else if (pwrState == PW_SELF_REFRESH && next_pwrState == PW_ACTIVE) xsrdCnt <= SR_EXIT_READ_DELAY;
      else if (xsrdCnt != '0) xsrdCnt <= xsrdCnt - 1'b1;
   end
   // registered state outputs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         powerDown       <= 1'b0;
         activePowerDown <= 1'b0;
         selfRefresh     <= 1'b0;
         dllEnable       <= 1'b1;
         odtAllowed      <= 1'b0;
         readPermitted   <= 1'b1;
         refreshPulse    <= 1'b0;
      end else begin
         powerDown <= (next_pwrState == PW_POWER_DOWN);
         if (pwrState == PW_ACTIVE && pdEnter && !srEnter) activePowerDown <= (bankOpen != '0);
         selfRefresh <= (next_pwrState == PW_SELF_REFRESH);
         dllEnable <= (next_pwrState != PW_SELF_REFRESH);
         odtAllowed <= odtOn && (next_pwrState != PW_SELF_REFRESH);
         // exit edge itself stays closed: the delay counter loads only on that edge
         readPermitted <= (xsrdCnt <= 8'h01) && (next_pwrState == PW_ACTIVE) && (pwrState == PW_ACTIVE);
         refreshPulse <= cmdRef && allIdle && (pwrState == PW_ACTIVE);
      end
   end

   // ---------------------------------------------------------------
   // write data path with byte mask
   // ---------------------------------------------------------------
   // masked bytes are dropped
   wire wrKeep = wrDataValid && !dataMask;
   dcc_fifo #(
      .WIDTH(DQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk (core_clk),
      .rst      (rst),
      .inValid  (wrKeep),
      .inData   (wrData),
      .inReady  (wrDataReady),
      .outValid (arrayWrValid),
      .outData  (arrayWrData),
      .outReady (arrayWrReady)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_sr_dll_off: assert property (selfRefresh |-> !dllEnable) else $error("dll on in self refresh");
   a_sr_no_odt: assert property (selfRefresh |-> !odtAllowed) else $error("odt in self refresh");
   a_pd_no_ref: assert property ((pwrState == PW_POWER_DOWN) |=> !refreshPulse) else $error("refresh in power down");
   a_sr_entry_idle: assert property ((pwrState == PW_SELF_REFRESH) |-> bankOpen == '0) else $error("self refresh with open bank");
   a_read_gate: assert property ($fell(selfRefresh) |-> !readPermitted [*8]) else $error("read opened early");
   a_mask_drop: assert property (wrDataValid && dataMask |=> $stable(u_wr_fifo.wrPtr)) else $error("masked byte stored");
   a_nop_idle: assert property (isNop && pwrState == PW_ACTIVE && !colBusy |=> !colStart) else $error("nop started");
   a_pre_close: assert property (cmdPre && preAll |=> bankOpen == '0) else $error("precharge all left row");
   c_pd: cover property (pdEnter ##[1:20] powerDown);
   c_sr: cover property (srEnter ##[1:50] !selfRefresh);
   c_col: cover property (colIn ##[1:8] colStart);
   c_ap_pd: cover property ($rose(activePowerDown));
   c_read_open: cover property ($rose(readPermitted));

   // helper: clocks since the last self refresh exit, saturating
   // kept apart from the delay counter so the check does not copy it
   logic [CNT_W-1:0] sinceExit;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) sinceExit <= '1;
      else if (selfRefresh) sinceExit <= '0;
      else if (sinceExit != '1) sinceExit <= sinceExit + 1'b1;
   end
   // no read permission inside exit window
   a_read_window: assert property (readPermitted |-> sinceExit >= SR_EXIT_READ_DELAY) else $error("read too early");
endmodule

/* dcc_ctrl_model.sv */
`timescale 1ns/10ps
module dcc_ctrl_model (
   // clock
   input  wire logic                 core_clk,
   // command pins towards the device
   output logic                      cke,
   output logic                      csN,
   output logic                      rasN,
   output logic                      casN,
   output logic                      weN,
   output logic [dcc_pkg::BA_W-1:0]  bankAddr,
   output logic [dcc_pkg::ROW_W-1:0] addr
);
   import dcc_pkg::*;
   // idle: clock enable low, device deselected
   initial begin
      cke = 1'b0;
      {csN, rasN, casN, weN} = 4'hf;
      bankAddr = '0;
      addr = '0;
   end
   // one edge each
   // command stands one edge, then a no-op; address flipped so stale values never match
   task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [13:0] a);
      @(posedge core_clk);
      {csN, rasN, casN, weN} <= c;
      bankAddr <= ba;
      addr <= a;
      @(posedge core_clk);
      {csN, rasN, casN, weN} <= 4'h7;
      addr <= ~a;
   endtask
   // no-op around cke
   // cke only moves under no-op and holds far past three registered edges
   task automatic setCke(input logic v);
      @(posedge core_clk);
      cke <= v;
      repeat (8) @(posedge core_clk);
   endtask
   // refresh with fall
   // refresh held across the fall because the device sees cke late; callers keep banks idle
   task automatic enterSelfRefresh();
      @(posedge core_clk);
      {csN, rasN, casN, weN} <= 4'h1;
      cke <= 1'b0;
      repeat (8) @(posedge core_clk);
      {csN, rasN, casN, weN} <= 4'h7;
   endtask
endmodule

/* ddr2_command_cke_state_control_tb.sv */
`timescale 1ns/10ps
module ddr2_command_cke_state_control_tb;
   import dcc_pkg::*;
   // ---------------------------------------------------------------
   // signals and model state
   // ---------------------------------------------------------------
   logic                  core_clk, rst, cke, csN, rasN, casN, weN;
   logic [BA_W-1:0]       bankAddr;
   logic [ROW_W-1:0]      addr;
   logic                  wrDataValid, dataMask, arrayWrValid, arrayWrReady, wrDataReady;
   logic [DQ_W-1:0]       wrData, arrayWrData;
   logic [BANK_N-1:0]     bankOpen, expOpen;
   logic                  powerDown, activePowerDown, selfRefresh, dllEnable;
   logic                  odtAllowed, readPermitted, colStart, colIsWrite, refreshPulse;
   logic [COL_W-1:0]      colAddr;
   logic [31:0]           seed;
   logic                  drainEn, took;
   logic [1:0]            stallCnt;
   logic [DQ_W-1:0]       expQ[$];
   int                    errCount, nChecks, al, lat0, lat, n;
   dcc_cmd_ctrl i_dut (.core_clk(core_clk), .rst(rst), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .bankAddr(bankAddr), .addr(addr), .wrDataValid(wrDataValid), .wrData(wrData),
      .dataMask(dataMask), .arrayWrValid(arrayWrValid), .arrayWrData(arrayWrData),
      .arrayWrReady(arrayWrReady), .wrDataReady(wrDataReady), .bankOpen(bankOpen), .powerDown(powerDown),
      .activePowerDown(activePowerDown), .selfRefresh(selfRefresh), .dllEnable(dllEnable),
      .odtAllowed(odtAllowed), .readPermitted(readPermitted), .colStart(colStart),
      .colIsWrite(colIsWrite), .colAddr(colAddr), .refreshPulse(refreshPulse));
   dcc_ctrl_model i_ctrl (.core_clk(core_clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .bankAddr(bankAddr), .addr(addr));
   // clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      nChecks++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // bounded wait: 0 power down, 1 self refresh, 2 read permission
   task automatic waitSig(input int which, input logic v, output int k);
      logic s;
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
         s = (which == 0) ? powerDown : (which == 1) ? selfRefresh : readPermitted;
      end while (s !== v && k < 400);
      if (s !== v) begin
         chk(0, 1, "wait ran out");
         summarize();
      end
   endtask
   // one command, watch pulses for 16 edges, then compare with the bank model
   task automatic step(input logic [3:0] c, input logic [1:0] ba, input logic [13:0] a);
      int nc;
      int nr;
      logic idle;
      nc = 0;
      nr = 0;
      idle = (expOpen == 4'h0);
      i_ctrl.cmd(c, ba, a);
      // refresh pulse stands only in the cycle right after the command edge
      #1;
      if (refreshPulse === 1'b1) nr++;
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         #1;
         if (colStart === 1'b1) begin
            nc++;
            lat = i;
            chk(colAddr, a[COL_W-1:0], "column address");
            chk(colIsWrite, c == 4'h4, "column kind");
         end
         if (refreshPulse === 1'b1) nr++;
      end
      case (c)
         4'h3: expOpen[ba] = 1'b1;
         4'h2: if (a[AUTO_PRE_BIT]) expOpen = '0; else expOpen[ba] = 1'b0;
         4'h4, 4'h5: if (a[AUTO_PRE_BIT]) expOpen[ba] = 1'b0;
         4'h0: if (idle && ba == MR_EXT1) al = a[AL_LSB +: AL_W];
         default: ;
      endcase
      chk(nc, (c == 4'h4 || c == 4'h5) ? 1 : 0, "column pulses");
      chk(nr, (c == 4'h1 && idle) ? 1 : 0, "refresh pulses");
      chk(bankOpen, expOpen, "open banks");
   endtask
   // offer one byte, give up after lim edges without room
   task automatic pushByte(input logic m, input int lim, output logic ok);
      logic r;
      int k;
      seed = xs(seed);
      wrDataValid <= 1'b1;
      wrData <= seed[7:0];
      dataMask <= m;
      k = 0;
      do begin
         @(negedge core_clk);
         r = wrDataReady;
         @(posedge core_clk);
         k++;
      end while (r !== 1'b1 && k < lim);
      ok = (r === 1'b1);
      if (ok && !m) expQ.push_back(seed[7:0]);
   endtask
   // far side drains three edges of four, so it stalls now and then
   always @(posedge core_clk) begin
      if (rst) begin
         stallCnt     <= 2'h0;
         arrayWrReady <= 1'b0;
      end else begin
         stallCnt     <= stallCnt + 2'h1;
         arrayWrReady <= drainEn & (stallCnt != 2'h0);
      end
   end
   always @(negedge core_clk) begin
      if (arrayWrValid === 1'b1 && arrayWrReady === 1'b1) begin
         if (expQ.size() == 0) chk(0, 1, "extra byte");
         else chk(arrayWrData, expQ.pop_front(), "stored byte");
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h02acbd6c;
      errCount = 0;
      nChecks = 0;
      al = 0;
      n = 0;
      wrDataValid = 1'b0;
      dataMask = 1'b0;
      drainEn = 1'b0;
      wrData = '0;
      expOpen = '0;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk({bankOpen, powerDown, selfRefresh, dllEnable, readPermitted}, 8'h03, "reset state");
      @(posedge core_clk);
      rst <= 1'b0;
      i_ctrl.setCke(1'b1);
      seed = xs(seed);
      step(4'h2, 2'h3, 14'h0000);
      step(4'h3, 2'h3, seed[13:0]);
      step(4'h3, 2'h0, seed[27:14]);
      step(4'hb, 2'h1, seed[13:0]);
      step(4'hd, 2'h0, seed[13:0]);
      step(4'h7, 2'h2, seed[13:0]);
      step(4'h5, 2'h0, {4'h0, seed[9:0]});
      lat0 = lat;
      step(4'h4, 2'h3, {4'h1, seed[19:10]});
      chk(lat, lat0, "write latency");
      step(4'h1, 2'h0, 14'h0000);
      step(4'h0, 2'h1, 14'h0010);
      step(4'h2, 2'h0, 14'h0400);
      step(4'h1, 2'h2, seed[13:0]);
      step(4'h0, 2'h1, 14'h0014);
      chk(odtAllowed, 1'b1, "termination enabled");
      step(4'h0, 2'h0, 14'h0028);
      step(4'h3, 2'h0, seed[23:10]);
      step(4'h5, 2'h0, {4'h0, seed[29:20]});
      chk(lat, lat0 + al, "additive latency");
      step(4'h3, 2'h1, seed[13:0]);
      i_ctrl.setCke(1'b0);
      waitSig(0, 1'b1, n);
      chk(activePowerDown, 1'b1, "active power down");
      i_ctrl.setCke(1'b1);
      waitSig(0, 1'b0, n);
      step(4'h2, 2'h0, 14'h0400);
      i_ctrl.setCke(1'b0);
      waitSig(0, 1'b1, n);
      chk({activePowerDown, odtAllowed}, 2'h1, "precharge power down");
      i_ctrl.setCke(1'b1);
      waitSig(0, 1'b0, n);
      i_ctrl.enterSelfRefresh();
      waitSig(1, 1'b1, n);
      chk({dllEnable, odtAllowed}, 2'h0, "self refresh outputs");
      i_ctrl.setCke(1'b1);
      #1;
      chk({selfRefresh, dllEnable, readPermitted}, 3'h2, "self refresh exit");
      waitSig(2, 1'b1, n);
      chk(n + 8 >= 200 && n + 8 <= 206, 1'b1, "read delay after exit");
      n = 0;
      do begin
         pushByte(1'b0, 1, took);
         if (took) n++;
      end while (took && n < 20);
      wrDataValid <= 1'b0;
      chk(n, FIFO_DEPTH, "buffer fill level");
      drainEn <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         pushByte(seed[9], 50, took);
      end
      wrDataValid <= 1'b0;
      for (int i = 0; i < 200 && expQ.size() > 0; i++) @(posedge core_clk);
      chk(expQ.size(), 0, "buffer drained");
      summarize();
   end
endmodule
